// ---- urm_uart_regs.v ----
`timescale 1ns/1ps
`include "urm_defines.vh"
module urm_uart_regs #(
  parameter WIDTH = 8
) (
  input wire core_clk,
  input wire rst,
  input wire [2:0] addr,
  input wire cs,
  input wire rd_stb,
  input wire wr_stb,
  input wire [7:0] wr_data,
  output reg [7:0] rd_data,
  input wire rx_char_valid,
  input wire [7:0] rx_char,
  input wire [3:0] line_err_set,
  input wire tx_taken,
  input wire tx_idle,
  input wire tx_shift_en,
  output wire tx_serial_out,
  input wire [3:0] modem_pins,
  output reg [7:0] tx_holding_q,
  output wire tx_holding_full,
  output wire [15:0] baud_divisor,
  output wire [7:0] line_format_control,
  output wire [4:0] modem_output_control,
  output wire interrupt_output
);
  reg [3:0] ien_q;
  reg [7:0] lfc_q, moc_q, scr_q, dll_q, dlm_q, rbr_q;
  reg dr_q, tx_holding_empty_flag_q, tx_holding_empty_flag_irq_q;
  reg [3:0] lerr_q;
  reg [3:0] delta_q;
  reg [3:0] pin_s1_q, pin_s2_q, pin_prev_q;
  reg [7:0] iid_d;
  wire [3:0] lerr_d;
  wire [3:0] delta_d;

  // Offset compare, shared by the strobe decodes; the read data mux cases on addr directly
  function sel_hit;
    input [2:0] a;
    input [2:0] ofs;
    begin
      sel_hit = (a == ofs);
    end
  endfunction

  // Line status byte built from named bit positions
  function [7:0] lst_pack;
    input ready;
    input [3:0] errs;
    input hold_empty;
    input all_empty;
    begin
      lst_pack = 8'h00;
      lst_pack[`URM_LST_DR] = ready;
      lst_pack[`URM_LST_ERR +: `URM_FLAG_W] = errs;
      lst_pack[`URM_LST_TX_HOLDING_EMPTY_FLAG] = hold_empty;
      lst_pack[`URM_LST_TEMT] = all_empty;
    end
  endfunction

  // Divisor bytes shadow data and enables while divisor_access_select is set
  wire divisor_access_select = lfc_q[`URM_LFC_DIVISOR_ACCESS_SELECT];
  wire wr = cs & wr_stb;
  wire rd = cs & rd_stb;
  wire rd_rbr = rd & sel_hit(addr, `URM_OFS_DATA) & ~divisor_access_select;
  wire wr_thr = wr & sel_hit(addr, `URM_OFS_DATA) & ~divisor_access_select;
  wire wr_dll = wr & sel_hit(addr, `URM_OFS_DATA) & divisor_access_select;
  wire wr_dlm = wr & sel_hit(addr, `URM_OFS_IEN) & divisor_access_select;
  wire wr_ien = wr & sel_hit(addr, `URM_OFS_IEN) & ~divisor_access_select;
  wire wr_scr = wr & sel_hit(addr, `URM_OFS_SCR);
  wire rd_lst = rd & sel_hit(addr, `URM_OFS_LST);
  wire rd_mis = rd & sel_hit(addr, `URM_OFS_MIS);
  wire rd_iid = rd & sel_hit(addr, `URM_OFS_IID);
  wire [3:0] pin_chg = pin_s2_q ^ pin_prev_q;
  wire src_line = ien_q[`URM_IEN_LINE] & (|lerr_q);
  wire src_rx = ien_q[`URM_IEN_RX] & dr_q;
  wire src_tx = ien_q[`URM_IEN_TX] & tx_holding_empty_flag_irq_q;
  wire src_modem = ien_q[`URM_IEN_MODEM] & (|delta_q);
  // All four gated by their enable; all clear means silent
  assign interrupt_output = src_line | src_rx | src_tx | src_modem;
  assign baud_divisor = {dlm_q, dll_q};
  assign line_format_control = lfc_q;
  assign modem_output_control = moc_q[4:0];
  assign tx_holding_full = ~tx_holding_empty_flag_q;

  genvar g;
  generate
    for (g = 0; g < `URM_FLAG_W; g = g + 1) begin : g_sticky
      // A fresh event beats the clearing read, so none is lost
      assign lerr_d[g] = line_err_set[g] | (lerr_q[g] & ~rd_lst);
      assign delta_d[g] = pin_chg[g] | (delta_q[g] & ~rd_mis);
    end
  endgenerate

  // Pins are asynchronous: only the second stage and its delayed copy feed logic.
  // No reset, so the change detector wakes at the pin level and
  // reset release shows no false change; reset must last three clocks.
  always @(posedge core_clk) begin
    pin_s1_q <= modem_pins;
    pin_s2_q <= pin_s1_q;
    pin_prev_q <= pin_s2_q;
  end

  urm_shifter #(.WIDTH(WIDTH)) u_tx (
    .core_clk(core_clk),
    .rst(rst),
    .load(tx_taken),
    .load_data(tx_holding_q),
    .shift_en(tx_shift_en),
    .serial_in(1'b1),
    .serial_out(tx_serial_out),
    .shift_q()
  );

  always @* begin
    if (src_line) begin
      iid_d = `URM_IID_LINE;
    end else if (src_rx) begin
      iid_d = `URM_IID_RX;
    end else if (src_tx) begin
      iid_d = `URM_IID_TX;
    end else if (src_modem) begin
      iid_d = `URM_IID_MODEM;
    end else begin
      iid_d = `URM_IID_NONE;
    end
  end

  // Bytes that keep no reset value sit apart so reset does not
  // gate their load enables
  always @(posedge core_clk) begin
    if (wr_dll) begin
      dll_q <= wr_data;
    end
    if (wr_dlm) begin
      dlm_q <= wr_data;
    end
    if (wr_scr) begin
      scr_q <= wr_data;
    end
    if (wr_thr) begin
      tx_holding_q <= wr_data;
    end
    if (rx_char_valid) begin
      rbr_q <= rx_char;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      ien_q <= 4'h0;
      lfc_q <= 8'h00;
      moc_q <= 8'h00;
      dr_q <= 1'b0;
      tx_holding_empty_flag_q <= 1'b1;
      tx_holding_empty_flag_irq_q <= 1'b0;
      lerr_q <= 4'h0;
      delta_q <= 4'h0;
      rd_data <= 8'h00;
    end else begin
      if (wr_ien) begin
        ien_q <= wr_data[`URM_IEN_MODEM:`URM_IEN_RX];
      end
      if (wr & sel_hit(addr, `URM_OFS_LFC)) begin
        lfc_q <= wr_data;
      end
      if (wr & sel_hit(addr, `URM_OFS_MOC)) begin
        moc_q <= wr_data & `URM_MOC_MASK;
      end
      // A byte written as the shifter takes the old one leaves the
      // holding register full, so the write wins here
      if (wr_thr) begin
        tx_holding_empty_flag_q <= 1'b0;
      end else if (tx_taken) begin
        tx_holding_empty_flag_q <= 1'b1;
      end
      // Empty event wins over the identity read that would clear it
      if (tx_taken & ~wr_thr) begin
        tx_holding_empty_flag_irq_q <= 1'b1;
      end else if (wr_thr | (rd_iid & (iid_d == `URM_IID_TX))) begin
        tx_holding_empty_flag_irq_q <= 1'b0;
      end
      // New character wins over the buffer read
      if (rx_char_valid) begin
        dr_q <= 1'b1;
      end else if (rd_rbr) begin
        dr_q <= 1'b0;
      end
      // Sticky flags take their next value from the per-bit loop
      lerr_q <= lerr_d;
      delta_q <= delta_d;
      // Read data is registered and holds until the next read
      if (rd) begin
        case (addr)
          `URM_OFS_DATA: rd_data <= divisor_access_select ? dll_q : rbr_q;
          `URM_OFS_IEN: rd_data <= divisor_access_select ? dlm_q : {4'h0, ien_q};
          `URM_OFS_IID: rd_data <= iid_d;
          `URM_OFS_LFC: rd_data <= lfc_q;
          `URM_OFS_MOC: rd_data <= moc_q;
          `URM_OFS_LST: rd_data <= lst_pack(dr_q, lerr_q, tx_holding_empty_flag_q, tx_holding_empty_flag_q & tx_idle);
          `URM_OFS_MIS: rd_data <= {pin_s2_q, delta_q};
          `URM_OFS_SCR: rd_data <= scr_q;
          default: rd_data <= 8'h00;
        endcase
      end
    end
  end
endmodule // urm_uart_regs

// ---- urm_defines.vh ----
`ifndef URM_DEFINES_VH
`define URM_DEFINES_VH
`define URM_OFS_DATA 3'h0
`define URM_OFS_IEN 3'h1
`define URM_OFS_IID 3'h2
`define URM_OFS_LFC 3'h3
`define URM_OFS_MOC 3'h4
`define URM_OFS_LST 3'h5
`define URM_OFS_MIS 3'h6
`define URM_OFS_SCR 3'h7
`define URM_IEN_RX 0
`define URM_IEN_TX 1
`define URM_IEN_LINE 2
`define URM_IEN_MODEM 3
`define URM_IEN_MASK 8'h0f
`define URM_LFC_DIVISOR_ACCESS_SELECT 7
`define URM_MOC_MASK 8'h1f
`define URM_LST_RESET 8'h60
`define URM_LST_DR 0
`define URM_LST_TX_HOLDING_EMPTY_FLAG 5
`define URM_LST_TEMT 6
`define URM_LST_ERR 1
`define URM_FLAG_W 4
`define URM_IID_NONE 8'h01
`define URM_IID_LINE 8'h06
`define URM_IID_RX 8'h04
`define URM_IID_TX 8'h02
`define URM_IID_MODEM 8'h00
`define URM_MIS_DCD 3
`endif

// ---- urm_shifter.v ----
`timescale 1ns/1ps
// Serial shifter core: loads byte, shifts out from bit 0.
module urm_shifter #(
  parameter WIDTH = 8
) (
  input wire core_clk,
  input wire rst,
  input wire load,
  input wire [WIDTH-1:0] load_data,
  input wire shift_en,
  input wire serial_in,
  output wire serial_out,
  output reg [WIDTH-1:0] shift_q
);
  reg [WIDTH-1:0] shift_d;
  assign serial_out = shift_q[0];
  always @* begin
    shift_d = shift_q;
    if (load) begin
      shift_d = load_data;
    end else if (shift_en) begin
      shift_d = {serial_in, shift_q[WIDTH-1:1]};
    end
  end
  always @(posedge core_clk) begin
    if (rst) begin
      shift_q <= {WIDTH{1'b0}};
    end else begin
      shift_q <= shift_d;
    end
  end
endmodule // urm_shifter

// ---- urm_uart_regs_assertions.sv ----
`timescale 1ns/1ps
module urm_uart_regs_chk(
  input wire core_clk,
  input wire rst,
  input wire [2:0] addr,
  input wire cs,
  input wire rd_stb,
  input wire wr_stb,
  input wire [7:0] wr_data,
  input wire [7:0] rd_data,
  input wire tx_taken,
  input wire tx_serial_out,
  input wire [7:0] tx_holding_q,
  input wire tx_holding_full,
  input wire [7:0] line_format_control,
  input wire interrupt_output
);
  wire w = cs && wr_stb;
  wire r = cs && rd_stb;
  wire dl = line_format_control[7];
  wire h0 = tx_holding_q[0];
  wire [3:0] wl = wr_data[3:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ien_upper_a: assert property (r && addr == 3'h1 && !dl |=> rd_data[7:4] == 4'h0) else $error("ien high");
  ien_rw_a: assert property (w && addr == 3'h1 && !dl ##1 !w ##1 r && addr == 3'h1 && !dl |=>
    rd_data[3:0] == $past(wl, 3)) else $error("ien rw");
  iid_pend_a: assert property (r && addr == 3'h2 |=> rd_data[0] == !$past(interrupt_output)) else $error("iid");
  lfc_wr_a: assert property (w && addr == 3'h3 |=> line_format_control == $past(wr_data)) else $error("lfc");
  thr_load_a: assert property (w && addr == 3'h0 && !dl && !tx_taken |=>
    tx_holding_full && tx_holding_q == $past(wr_data)) else $error("thr");
  tx_lsb_a: assert property (tx_taken |=> tx_serial_out == $past(h0)) else $error("lsb");
  ien_off_a: assert property (w && addr == 3'h1 && !dl && wl == 4'h0 |=> !interrupt_output) else $error("off");
  irq_needs_en_a: assert property (interrupt_output && r && addr == 3'h1 && !dl |=> rd_data[3:0] != 4'h0)
    else $error("no enable");
  cover property (r && addr == 3'h2 && interrupt_output);
  cover property (tx_taken);
  cover property (w && addr == 3'h0 && dl);
endmodule // urm_uart_regs_chk
bind urm_uart_regs urm_uart_regs_chk u_chk(.core_clk, .rst, .addr, .cs, .rd_stb, .wr_stb, .wr_data, .rd_data,
  .tx_taken, .tx_serial_out, .tx_holding_q, .tx_holding_full, .line_format_control, .interrupt_output);

// ---- urm_line_model.sv ----
`timescale 1ns/1ps
module urm_line_model(
  input wire core_clk,
  input wire tx_serial_out,
  output reg tx_taken,
  output reg tx_idle,
  output reg tx_shift_en,
  output reg rx_char_valid,
  output reg [7:0] rx_char,
  output reg [3:0] line_err_set,
  output reg [3:0] modem_pins
);
  integer i;
  initial {tx_taken, tx_idle, tx_shift_en, rx_char_valid, rx_char, line_err_set, modem_pins} = {4'h4, 8'h5a, 8'h00};
  task send_tx(output [7:0] b); begin
    @(posedge core_clk) #1 tx_taken = 1;
    tx_idle = 0;
    @(posedge core_clk) #1 tx_taken = 0;
    tx_shift_en = 1;
    for (i = 0; i < 8; i = i + 1) begin
      b[i] = tx_serial_out;
      @(posedge core_clk) #1;
    end
    tx_shift_en = 0;
    tx_idle = 1;
  end endtask
  task send_rx(input [7:0] c, input [3:0] e); begin
    @(posedge core_clk) #1 rx_char = c;
    rx_char_valid = 1;
    line_err_set = e;
    // Stale character inverted so a late sample cannot pass
    @(posedge core_clk) #1 rx_char = ~c;
    rx_char_valid = 0;
    line_err_set = 0;
  end endtask
  task set_pins(input [3:0] p); begin
    @(posedge core_clk) #1 modem_pins = p;
  end endtask
endmodule // urm_line_model

// ---- tb_urm_uart_regs.sv ----
`timescale 1ns/1ps
module tb_urm_uart_regs;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg cs = 1'b0;
  reg rd_stb = 1'b0;
  reg wr_stb = 1'b0;
  reg [2:0] addr = 3'h0;
  reg [7:0] wr_data = 8'h00;
  reg [7:0] v;
  integer n_mismatch = 0;
  integer total_checks = 0;
  wire [7:0] rd_data, rx_char, tx_holding_q;
  wire [3:0] line_err_set, modem_pins;
  wire tx_taken, tx_idle, tx_shift_en, tx_serial_out, rx_char_valid, tx_holding_full, interrupt_output;
  wire [15:0] baud_divisor;
  wire [7:0] line_format_control;
  wire [4:0] modem_output_control;
  always #12.5 core_clk = ~core_clk;
  urm_uart_regs i_urm_uart_regs(.core_clk, .rst, .addr, .cs, .rd_stb, .wr_stb, .wr_data, .rd_data, .rx_char_valid,
    .rx_char, .line_err_set, .tx_taken, .tx_idle, .tx_shift_en, .tx_serial_out, .modem_pins, .tx_holding_q,
    .tx_holding_full, .baud_divisor, .line_format_control, .modem_output_control, .interrupt_output);
  urm_line_model u_line(.core_clk, .tx_serial_out, .tx_taken, .tx_idle, .tx_shift_en, .rx_char_valid, .rx_char,
    .line_err_set, .modem_pins);
  task chk(input string nm, input [7:0] e, input [7:0] g); begin
    total_checks = total_checks + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  end endtask
  task acc(input [2:0] a, input w, input [7:0] d); begin
    @(posedge core_clk) #1 cs = 1;
    addr = a;
    wr_stb = w;
    rd_stb = !w;
    wr_data = d;
    @(posedge core_clk) #1 cs = 0;
    wr_stb = 0;
    rd_stb = 0;
    v = rd_data;
  end endtask
  task rc(input string nm, input [2:0] a, input [7:0] e); begin
    acc(a, 0, 8'h00);
    chk(nm, e, v);
  end endtask
  task irq(input b); chk("irq", {7'h0, b}, {7'h0, interrupt_output}); endtask
  task close_out; begin
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  end endtask
  initial begin
    repeat (3000) @(posedge core_clk);
    n_mismatch = n_mismatch + 1;
    close_out;
  end
  initial begin
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    rc("ien", 3'h1, 8'h00);
    acc(3'h1, 1'b1, 8'hff);
    rc("ien", 3'h1, 8'h0f);
    acc(3'h3, 1'b1, 8'h80);
    acc(3'h0, 1'b1, 8'h34);
    acc(3'h1, 1'b1, 8'h12);
    rc("dll", 3'h0, 8'h34);
    rc("dlm", 3'h1, 8'h12);
    chk("div_lo", 8'h34, baud_divisor[7:0]);
    chk("div_hi", 8'h12, baud_divisor[15:8]);
    acc(3'h3, 1'b1, 8'h03);
    rc("lfc", 3'h3, 8'h03);
    chk("lfc_out", 8'h03, line_format_control);
    rc("ien", 3'h1, 8'h0f);
    acc(3'h4, 1'b1, 8'hff);
    rc("moc", 3'h4, 8'h1f);
    chk("moc_out", 8'h1f, {3'h0, modem_output_control});
    $display("register map done");
    acc(3'h1, 1'b1, 8'h00);
    acc(3'h0, 1'b1, 8'ha5);
    chk("full", 8'h01, {7'h0, tx_holding_full});
    u_line.send_tx(v);
    chk("tx", 8'ha5, v);
    chk("full", 8'h00, {7'h0, tx_holding_full});
    irq(1'b0);
    acc(3'h1, 1'b1, 8'h02);
    irq(1'b1);
    rc("iid", 3'h2, 8'h02);
    irq(1'b0);
    u_line.send_rx(8'h3c, 4'h0);
    irq(1'b0);
    acc(3'h1, 1'b1, 8'h05);
    irq(1'b1);
    u_line.send_rx(8'hc3, 4'h1);
    rc("iid", 3'h2, 8'h06);
    rc("lst", 3'h5, 8'h63);
    rc("iid", 3'h2, 8'h04);
    rc("rbr", 3'h0, 8'hc3);
    irq(1'b0);
    $display("interrupt sources done");
    acc(3'h1, 1'b1, 8'h08);
    u_line.set_pins(4'h8);
    repeat (4) @(posedge core_clk) #1;
    irq(1'b1);
    rc("ien", 3'h1, 8'h08);
    rc("msr", 3'h6, 8'h88);
    irq(1'b0);
    $display("modem done");
    @(posedge core_clk) #1 rst = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    rc("ien", 3'h1, 8'h00);
    rc("iid", 3'h2, 8'h01);
    rc("lst", 3'h5, 8'h60);
    rc("lfc", 3'h3, 8'h00);
    rc("msr", 3'h6, 8'h80);
    irq(1'b0);
    $display("reset done");
    close_out;
  end
endmodule // tb_urm_uart_regs
